// file: hdl/sdpi_top.sv
// Purpose: Memory pin interface with system reset and strap capture
// Assumes: i_clk is the control clock; i_memory_clock_feedback is the
//          buffered copy of the memory clock and runs free
// Notes:   One access per request: activate, read or write, precharge
// Function
// RULE1 - Reset input low-to-high starts hard reset
// RULE2 - Drive system reset output for other components
// RULE3 - Capture data bits 40:0 as straps
// RULE4 - Low selects enable ranks; high masks commands
// RULE5 - Shared pin: select 2 or address 11
// RULE6 - Pin: select 3, address 12, bank 1
// RULE7 - Row then column on address 10:0
// RULE8 - Two active-low row strobe outputs
// RULE9 - Two active-low column strobe outputs
// RULE10 - Write enable high reads, low writes
// RULE11 - Eight byte masks block write data
// RULE12 - 64-bit two-way memory data bus
// RULE13 - Memory clock output from the PLL
// RULE14 - Controller logic runs on fed-back clock
// RULE15 - Dot clock direction from strap or bit
// RULE16 - Straps held stable, steer pin functions
`timescale 1ns/1ns
module sdpi_top
  import sdpi_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_memory_clock_feedback,
  input wire logic i_pll_mem_clk,
  input wire logic i_pll_dot_clk,
  input wire logic i_system_reset_in_n,
  input wire logic i_dot_dir_override,
  input wire logic i_dot_dir_drive,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [1:0] i_req_rank,
  input wire logic [1:0] i_req_bank,
  input wire logic [ADDR_W-1:0] i_req_row,
  input wire logic [COL_W-1:0] i_req_col,
  input wire logic [MASK_W-1:0] i_req_byte_en,
  input wire logic [DATA_W-1:0] i_req_wdata,
  input wire logic [DATA_W-1:0] i_memory_data_bus,
  output logic o_req_ready,
  output logic o_rd_valid,
  output logic [DATA_W-1:0] o_rd_data,
  output logic o_system_reset_out_n,
  output logic o_hard_reset,
  output logic [STRAP_W-1:0] o_strap_options,
  output logic o_memory_clock_output,
  output logic o_pixel_dot_clock,
  output logic o_pixel_dot_clock_oe,
  output logic [1:0] o_chip_select_n,
  output logic o_shared_select2_or_addr11,
  output logic o_shared_select3_addr12_bank1,
  output logic [10:0] o_memory_row_col_address,
  output logic o_bank_addr0,
  output logic [1:0] o_row_strobe_n,
  output logic [1:0] o_col_strobe_n,
  output logic o_memory_write_enable_n,
  output logic [MASK_W-1:0] o_data_mask,
  output logic [DATA_W-1:0] o_memory_data_bus,
  output logic o_memory_data_bus_oe
);

  // ==========================================================
  // Clocks passed out
  // ==========================================================
  // Memory clock comes straight from the PLL; its rate is set there
  assign o_memory_clock_output = i_pll_mem_clk; // [RULE13]
  assign o_pixel_dot_clock = i_pll_dot_clk;
  // Internal bit overrides the strap when software asks for it
  assign o_pixel_dot_clock_oe = i_dot_dir_override ? i_dot_dir_drive :
    o_strap_options[STRAP_DOT_DRIVE_BIT]; // [RULE15]

  // ==========================================================
  // Reset input, straps and reset output (control clock)
  // ==========================================================
  logic rst_in_s;
  logic [STRAP_W-1:0] strap_s;
  logic rst_in_prev;
  logic [7:0] hold_cnt;
  logic next_rst_in_prev;
  logic [7:0] next_hold_cnt;
  logic [STRAP_W-1:0] next_strap;
  logic next_rst_out_n;

  sdpi_sync #(.W(1)) u_rst_sync (
    .i_clk(i_clk),
    .i_d(i_system_reset_in_n),
    .o_q(rst_in_s)
  );

  // Straps pass the same two stages, so they line up with the edge
  sdpi_sync #(.W(STRAP_W)) u_strap_sync (
    .i_clk(i_clk),
    .i_d(i_memory_data_bus[STRAP_W-1:0]),
    .o_q(strap_s)
  );

  // Rising edge loads straps and starts the output stretch
  always_comb begin
    next_rst_in_prev = rst_in_s;
    next_hold_cnt = hold_cnt;
    next_strap = o_strap_options;
    if (rst_in_s && !rst_in_prev) begin // [RULE1]
      next_strap = strap_s; // [RULE3]
      next_hold_cnt = 8'(RESET_OUT_CYC);
    end else if (hold_cnt != 8'h00) begin
      next_hold_cnt = hold_cnt - 8'h01;
    end
    // Held low while the input is low and during the stretch
    next_rst_out_n = rst_in_s && rst_in_prev &&
      (next_hold_cnt == 8'h00); // [RULE2]
  end

  // Straps change only on a reset edge, never during operation
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rst_in_prev <= 1'b0;
      hold_cnt <= 8'h00;
      o_strap_options <= STRAP_RESET;
      o_system_reset_out_n <= 1'b0;
    end else begin
      rst_in_prev <= next_rst_in_prev;
      hold_cnt <= next_hold_cnt;
      o_strap_options <= next_strap; // [RULE16]
      o_system_reset_out_n <= next_rst_out_n;
    end
  end

  assign o_hard_reset = ~o_system_reset_out_n;

  // ==========================================================
  // Request handshake (control clock side)
  // ==========================================================
  logic req_tgl;
  logic ack_tgl;
  logic ack_s;
  logic ack_prev;
  logic busy;
  logic cmd_write;
  logic [1:0] cmd_rank;
  logic [1:0] cmd_bank;
  logic [ADDR_W-1:0] cmd_row;
  logic [COL_W-1:0] cmd_col;
  logic [MASK_W-1:0] cmd_be;
  logic [DATA_W-1:0] cmd_wdata;
  logic [DATA_W-1:0] rdata_l;
  logic next_req_tgl;
  logic next_busy;
  logic next_rd_valid;
  logic [DATA_W-1:0] next_rd_data;
  logic take;

  sdpi_sync #(.W(1)) u_ack_sync (
    .i_clk(i_clk),
    .i_d(ack_tgl),
    .o_q(ack_s)
  );

  assign o_req_ready = ~busy & o_system_reset_out_n;
  assign take = i_req_valid & o_req_ready;

  // Command word stays still while busy, so the memory side reads it
  // safely once it sees the toggle
  always_comb begin
    next_req_tgl = req_tgl;
    next_busy = busy;
    next_rd_valid = 1'b0;
    next_rd_data = o_rd_data;
    if (take) begin
      next_req_tgl = ~req_tgl;
      next_busy = 1'b1;
    end else if (busy && (ack_s != ack_prev)) begin
      next_busy = 1'b0;
      next_rd_valid = ~cmd_write;
      next_rd_data = cmd_write ? o_rd_data : rdata_l;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || o_hard_reset) begin
      req_tgl <= 1'b0;
      ack_prev <= 1'b0;
      busy <= 1'b0;
      o_rd_valid <= 1'b0;
      o_rd_data <= '0;
    end else begin
      req_tgl <= next_req_tgl;
      ack_prev <= ack_s;
      busy <= next_busy;
      o_rd_valid <= next_rd_valid;
      o_rd_data <= next_rd_data;
    end
  end

  // Command holding registers, loaded on acceptance only
  always_ff @(posedge i_clk) begin
    if (take) begin
      cmd_write <= i_req_write;
      cmd_rank <= i_req_rank;
      cmd_bank <= i_req_bank;
      cmd_row <= i_req_row;
      cmd_col <= i_req_col;
      cmd_be <= i_req_byte_en;
      cmd_wdata <= i_req_wdata;
    end
  end

  // ==========================================================
  // Memory side sequencer (fed-back memory clock)
  // ==========================================================
  logic mrst;
  logic req_s;
  logic req_prev;
  logic d16;
  logic four_bank;
  sdpi_state_e st;
  sdpi_state_e next_st;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [2:0] cmd_q;
  logic [2:0] next_cmd;
  logic [3:0] cs_q;
  logic [3:0] next_cs;
  logic [3:0] sel_n;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] next_addr;
  logic [1:0] ba_q;
  logic [1:0] next_ba;
  logic [MASK_W-1:0] next_mask;
  logic next_oe;
  logic next_ack;
  logic [DATA_W-1:0] next_rdata;

  sdpi_sync #(.W(1)) u_mrst_sync (
    .i_clk(i_memory_clock_feedback),
    .i_d(o_hard_reset | i_sys_rst),
    .o_q(mrst)
  );

  sdpi_sync #(.W(1)) u_req_sync (
    .i_clk(i_memory_clock_feedback),
    .i_d(req_tgl),
    .o_q(req_s)
  );

  // Rank select: four ranks with 16-Mbit parts, otherwise two
  always_comb begin
    sel_n = 4'hF;
    if (d16) begin
      sel_n[cmd_rank] = 1'b0;
    end else begin
      sel_n[cmd_rank[0]] = 1'b0;
    end
  end

  // Activate, wait, access, wait for data, precharge, wait, answer
  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_cmd = CMD_NOP;
    next_cs = 4'hF; // Deselected ranks ignore the command [RULE4]
    next_addr = addr_q;
    next_ba = ba_q;
    next_mask = '1;
    next_oe = 1'b0;
    next_ack = ack_tgl;
    next_rdata = rdata_l;
    case (st)
      SDPI_IDLE: begin
        if (req_s != req_prev) begin
          next_cmd = CMD_ACT;
          next_cs = sel_n; // [RULE4]
          next_addr = cmd_row; // Row first [RULE7]
          next_ba = cmd_bank;
          next_cnt = 4'(TRCD_CYC - 1);
          next_st = SDPI_RCD;
        end
      end
      SDPI_RCD: begin
        if (cnt == 4'h0) begin
          // High write enable reads, low writes [RULE10]
          next_cmd = cmd_write ? CMD_WRITE : CMD_READ;
          next_cs = sel_n;
          next_addr = {2'b00, cmd_col}; // Column second [RULE7]
          // Unenabled bytes masked so their write is blocked [RULE11]
          next_mask = cmd_write ? ~cmd_be : '0;
          next_oe = cmd_write; // [RULE12]
          next_cnt = cmd_write ? 4'h0 : 4'(CAS_LAT_CYC);
          next_st = SDPI_CAS;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      SDPI_CAS: begin
        next_mask = cmd_write ? '1 : '0;
        if (cnt == 4'h0) begin
          if (!cmd_write) begin
            next_rdata = i_memory_data_bus; // [RULE12]
          end
          next_cmd = CMD_PRE;
          next_cs = sel_n;
          next_cnt = 4'(TRP_CYC - 1);
          next_st = SDPI_RP;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      SDPI_RP: begin
        if (cnt == 4'h0) begin
          next_ack = ~ack_tgl;
          next_st = SDPI_IDLE;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      default: begin
        next_st = SDPI_IDLE;
      end
    endcase
  end

  // Straps are quasi-static here: taken over while this side is held
  // in reset, which always follows their capture
  always_ff @(posedge i_memory_clock_feedback) begin // [RULE14]
    if (mrst) begin
      d16 <= o_strap_options[STRAP_DENSITY16_BIT]; // [RULE16]
      four_bank <= o_strap_options[STRAP_FOUR_BANK_BIT];
      req_prev <= req_s;
      st <= SDPI_IDLE;
      cnt <= 4'h0;
      cmd_q <= CMD_NOP;
      cs_q <= 4'hF;
      addr_q <= '0;
      ba_q <= 2'h0;
      o_data_mask <= '1;
      o_memory_data_bus_oe <= 1'b0;
      ack_tgl <= 1'b0;
      rdata_l <= '0;
    end else begin
      req_prev <= (st == SDPI_IDLE) ? req_s : req_prev;
      st <= next_st;
      cnt <= next_cnt;
      cmd_q <= next_cmd;
      cs_q <= next_cs;
      addr_q <= next_addr;
      ba_q <= next_ba;
      o_data_mask <= next_mask;
      o_memory_data_bus_oe <= next_oe;
      ack_tgl <= next_ack;
      rdata_l <= next_rdata;
    end
  end

  // Write data register, loaded with the command word
  always_ff @(posedge i_memory_clock_feedback) begin
    o_memory_data_bus <= cmd_wdata;
  end

  // ==========================================================
  // Pin functions
  // ==========================================================
  assign o_chip_select_n = cs_q[1:0]; // [RULE4]
  assign o_memory_row_col_address = addr_q[10:0]; // [RULE7]
  assign o_bank_addr0 = ba_q[0];
  // Both strobes of a pair driven alike; each drives devices directly
  assign o_row_strobe_n = {2{cmd_q[2]}}; // [RULE8]
  assign o_col_strobe_n = {2{cmd_q[1]}}; // [RULE9]
  assign o_memory_write_enable_n = cmd_q[0]; // [RULE10]
  assign o_shared_select2_or_addr11 = d16 ? cs_q[2] : addr_q[11]; // [RULE5]
  assign o_shared_select3_addr12_bank1 = d16 ? cs_q[3] :
    (four_bank ? ba_q[1] : addr_q[12]); // [RULE6]

endmodule // sdpi_top

// file: hdl/sdpi_pkg.sv
// Purpose: Shared constants for the memory pin interface and reset straps
// Assumes: Control side at 20 MHz, memory side on the fed-back clock
// Notes:   Strap field positions are local choices
package sdpi_pkg;

  // ==========================================================
  // Clock rates and timing
  // ==========================================================
  localparam int CLK_MHZ = 20;
  localparam int MEM_CLK_DEFAULT_MHZ = 66;
  // Reset output stretch after the reset input rises (least time)
  localparam int RESET_OUT_NS = 1000;
  localparam int RESET_OUT_CYC = (RESET_OUT_NS * CLK_MHZ + 999) / 1000;
  // Memory timings, counted on the memory clock (least times)
  localparam int TRCD_NS = 20;
  localparam int TRP_NS = 20;
  localparam int TRCD_CYC = (TRCD_NS * MEM_CLK_DEFAULT_MHZ + 999) / 1000;
  localparam int TRP_CYC = (TRP_NS * MEM_CLK_DEFAULT_MHZ + 999) / 1000;
  localparam int CAS_LAT_CYC = 2;

  // ==========================================================
  // Widths
  // ==========================================================
  localparam int DATA_W = 64;
  localparam int MASK_W = 8;
  localparam int STRAP_W = 41;
  localparam int ADDR_W = 13;
  localparam int COL_W = 11;

  // ==========================================================
  // Strap field positions
  // ==========================================================
  localparam int STRAP_DENSITY16_BIT = 0;
  localparam int STRAP_FOUR_BANK_BIT = 1;
  localparam int STRAP_DOT_DRIVE_BIT = 2;
  localparam logic [STRAP_W-1:0] STRAP_RESET = 41'h000_0000_0000;

  // ==========================================================
  // Memory commands as {row strobe, column strobe, write enable}
  // ==========================================================
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_PRE = 3'h2;

  typedef enum logic [2:0] {
    SDPI_IDLE, SDPI_RCD, SDPI_CAS, SDPI_RP
  } sdpi_state_e;

endpackage

// file: hdl/sdpi_sync.sv
// Purpose: Two-flop level synchroniser, any width
// Assumes: Each bit is a level or a slowly changing quasi-static word
// Notes:   Only the second stage leaves this module
`timescale 1ns/1ns
module sdpi_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  // ==========================================================
  // Stages
  // ==========================================================
  // No reset: a reset here would only delay the first valid sample
  always_comb begin
    next_meta = i_d;
    next_q = meta;
  end

  always_ff @(posedge i_clk) begin
    meta <= next_meta;
    o_q <= next_q;
  end
endmodule // sdpi_sync

// file: verif/sdpi_assertions.sv
// Purpose: Port checks for the memory pin interface and reset straps
// Assumes: Commands decoded from strobe pair 0 and write enable
// Notes:   Memory side checks sleep while hard reset is up
`timescale 1ns/1ns
module sdpi_assertions
  import sdpi_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_memory_clock_feedback,
  input wire logic i_pll_mem_clk,
  input wire logic i_pll_dot_clk,
  input wire logic i_system_reset_in_n,
  input wire logic i_dot_dir_override,
  input wire logic i_dot_dir_drive,
  input wire logic o_system_reset_out_n,
  input wire logic o_hard_reset,
  input wire logic [STRAP_W-1:0] o_strap_options,
  input wire logic o_memory_clock_output,
  input wire logic o_pixel_dot_clock,
  input wire logic o_pixel_dot_clock_oe,
  input wire logic [1:0] o_chip_select_n,
  input wire logic [1:0] o_row_strobe_n,
  input wire logic [1:0] o_col_strobe_n,
  input wire logic o_memory_write_enable_n,
  input wire logic o_memory_data_bus_oe
);
  // ==========================================================
  // Command decode and steps of one access
  // ==========================================================
  wire logic [2:0] cmd;
  assign cmd = {o_row_strobe_n[0], o_col_strobe_n[0], o_memory_write_enable_n};
  sequence s_act;
    cmd == CMD_ACT;
  endsequence
  sequence s_rw;
    cmd == CMD_READ || cmd == CMD_WRITE;
  endsequence

  // ==========================================================
  // Reset and strap side, control clock
  // ==========================================================
  // Two sync flops plus a register leave three edges of lag, within the four allowed
  a_rst_enter:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !i_system_reset_in_n |-> ##[1:4] o_hard_reset) else $error("no reset");
  a_rst_stretch:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $rose(i_system_reset_in_n) |-> o_hard_reset [*8]) else $error("short");
  // Release only if the input was already high 20 edges earlier
  a_rst_out_pol:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $rose(o_system_reset_out_n) |-> !o_hard_reset &&
      $past(i_system_reset_in_n, 20)) else $error("reset out early");
  a_straps_hold:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !o_hard_reset |=> $stable(o_strap_options)) else $error("strap moved");
  a_dot_dir_sel:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_pixel_dot_clock_oe == (i_dot_dir_override ? i_dot_dir_drive :
      o_strap_options[STRAP_DOT_DRIVE_BIT])) else $error("dot dir");
  a_mclk_pass:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_memory_clock_output == i_pll_mem_clk) else $error("mem clock");
  a_dot_pass:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_pixel_dot_clock == i_pll_dot_clk) else $error("dot clock");

  // ==========================================================
  // Memory pins, fed-back clock
  // ==========================================================
  // Pins are unknown before the first reset edge: i_sys_rst guards that
  a_act_then_rw:
    assert property (@(posedge i_memory_clock_feedback)
      disable iff (i_sys_rst || o_hard_reset)
      s_act |=> cmd == CMD_NOP ##1 s_rw) else $error("bad order");
  a_rw_then_pre:
    assert property (@(posedge i_memory_clock_feedback)
      disable iff (i_sys_rst || o_hard_reset)
      s_rw |-> ##[1:4] cmd == CMD_PRE) else $error("no precharge");
  a_strobe_pair:
    assert property (@(posedge i_memory_clock_feedback)
      disable iff (i_sys_rst || o_hard_reset)
      o_row_strobe_n[1] == o_row_strobe_n[0] &&
      o_col_strobe_n[1] == o_col_strobe_n[0]) else $error("strobe pair");
  a_write_drive:
    assert property (@(posedge i_memory_clock_feedback)
      disable iff (i_sys_rst || o_hard_reset)
      cmd == CMD_WRITE |-> o_memory_data_bus_oe) else $error("wr no drive");
  a_read_float:
    assert property (@(posedge i_memory_clock_feedback)
      disable iff (i_sys_rst || o_hard_reset)
      cmd == CMD_READ |-> !o_memory_data_bus_oe) else $error("rd driven");
  a_rank_select:
    assert property (@(posedge i_memory_clock_feedback)
      disable iff (i_sys_rst || o_hard_reset)
      cmd == CMD_ACT && !o_strap_options[STRAP_DENSITY16_BIT] |->
      $onehot(~o_chip_select_n)) else $error("rank select");
endmodule // sdpi_assertions

bind sdpi_top sdpi_assertions u_sdpi_assertions (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_memory_clock_feedback(i_memory_clock_feedback),
  .i_pll_mem_clk(i_pll_mem_clk), .i_system_reset_in_n(i_system_reset_in_n),
  .i_pll_dot_clk(i_pll_dot_clk), .o_pixel_dot_clock(o_pixel_dot_clock),
  .i_dot_dir_override(i_dot_dir_override), .i_dot_dir_drive(i_dot_dir_drive),
  .o_system_reset_out_n(o_system_reset_out_n), .o_hard_reset(o_hard_reset),
  .o_strap_options(o_strap_options),
  .o_memory_clock_output(o_memory_clock_output),
  .o_pixel_dot_clock_oe(o_pixel_dot_clock_oe),
  .o_chip_select_n(o_chip_select_n), .o_row_strobe_n(o_row_strobe_n),
  .o_col_strobe_n(o_col_strobe_n),
  .o_memory_write_enable_n(o_memory_write_enable_n),
  .o_memory_data_bus_oe(o_memory_data_bus_oe));

// file: verif/sdpi_dimm_model.sv
// Purpose: Behavioural memory rank with strap drive during reset
// Assumes: Read data two clocks after the read command
// Notes:   Idle bus toggles so a stale value never reads as good
`timescale 1ns/1ns
module sdpi_dimm_model
  import sdpi_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_wide_sel,
  input wire logic i_strap_en,
  input wire logic [STRAP_W-1:0] i_strap,
  input wire logic [1:0] i_cs_n,
  input wire logic i_s2,
  input wire logic i_s3,
  input wire logic [10:0] i_ma,
  input wire logic i_ba0,
  input wire logic [2:0] i_cmd,
  input wire logic [MASK_W-1:0] i_dqm,
  input wire logic [DATA_W-1:0] i_dq,
  output logic [DATA_W-1:0] o_dq = '0,
  output logic [15:0] o_act_pins = '0,
  output logic [10:0] o_col_pins = '0
);
  logic [DATA_W-1:0] mem [logic [10:0]];
  logic [DATA_W-1:0] rd_q;
  logic rd_sh = 1'b0;
  logic sel;
  // Deselected ranks ignore every command
  assign sel = !(&i_cs_n) || (i_wide_sel && !(i_s2 && i_s3));
  // ==========================================================
  // Command decode, masked writes, delayed read data
  // ==========================================================
  always @(posedge i_mclk) begin
    rd_sh <= sel && i_cmd == CMD_READ;
    if (sel && i_cmd == CMD_ACT) o_act_pins <= {i_s3, i_s2, i_ba0, i_ma, i_cs_n};
    if (sel && (i_cmd == CMD_READ || i_cmd == CMD_WRITE)) o_col_pins <= i_ma;
    if (sel && i_cmd == CMD_READ) rd_q <= mem.exists(i_ma) ? mem[i_ma] : '0;
    if (sel && i_cmd == CMD_WRITE) begin
      for (int b = 0; b < MASK_W; b++) begin
        if (!i_dqm[b]) mem[i_ma][8*b+:8] = i_dq[8*b+:8];
      end
    end
    // Strap word while reset is low, else read data or a toggling bus;
    // data leaves one clock after the command so it is settled at the
    // second edge, where the controller samples it
    o_dq <= i_strap_en ? DATA_W'(i_strap) :
      rd_sh ? rd_q : ~o_dq;
  end
endmodule // sdpi_dimm_model

// file: verif/sdpi_top_tb_top.sv
// Purpose: Boots under three strap sets and runs masked accesses
// Assumes: Memory clock runs free at 32 ns, out of phase with i_clk
// Notes:   Every boot after the first is a reset in mid-run
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module sdpi_top_tb_top
  import sdpi_pkg::*;
;
  logic clk = 0, mclk = 0, pixel_dot_clock = 0, rst = 1, rin_n = 0, ovr = 0, drv = 0;
  logic vld = 0, wr = 0, wide = 0, sen = 1;
  logic [1:0] rank = 0, bank = 2'h3;
  logic [ADDR_W-1:0] row = 13'h0A53;
  logic [COL_W-1:0] col = 11'h2B3;
  logic [MASK_W-1:0] be = 0, dqm;
  logic [DATA_W-1:0] wd = 0, rdd, mdo, mdm, mdq;
  logic [STRAP_W-1:0] strap = 0, so;
  logic rdy, rdv, rso_n, hrst, mco, dco, dcoe, s2, s3, ba0, we_n, oe;
  logic [1:0] cs_n, ras_n, cas_n;
  logic [10:0] ma, colp;
  logic [15:0] actp;
  int error_cnt = 0, num_checks = 0, cyc = 0;
  // Bus level: the device wins while it drives, else the rank model
  assign mdq = oe ? mdo : mdm;
  always #25 clk = ~clk;
  always #9 pixel_dot_clock = ~pixel_dot_clock;
  initial begin
    #7;
    forever #16 mclk = ~mclk;
  end
  sdpi_top u_sdpi_top (.i_clk(clk), .i_sys_rst(rst),
    .i_memory_clock_feedback(mclk), .i_pll_mem_clk(mclk), .i_pll_dot_clk(pixel_dot_clock),
    .i_system_reset_in_n(rin_n), .i_dot_dir_override(ovr),
    .i_dot_dir_drive(drv), .i_req_valid(vld), .i_req_write(wr),
    .i_req_rank(rank), .i_req_bank(bank), .i_req_row(row), .i_req_col(col),
    .i_req_byte_en(be), .i_req_wdata(wd), .i_memory_data_bus(mdq),
    .o_req_ready(rdy), .o_rd_valid(rdv), .o_rd_data(rdd),
    .o_system_reset_out_n(rso_n), .o_hard_reset(hrst), .o_strap_options(so),
    .o_memory_clock_output(mco), .o_pixel_dot_clock(dco),
    .o_pixel_dot_clock_oe(dcoe), .o_chip_select_n(cs_n),
    .o_shared_select2_or_addr11(s2), .o_shared_select3_addr12_bank1(s3),
    .o_memory_row_col_address(ma), .o_bank_addr0(ba0), .o_row_strobe_n(ras_n),
    .o_col_strobe_n(cas_n), .o_memory_write_enable_n(we_n), .o_data_mask(dqm),
    .o_memory_data_bus(mdo), .o_memory_data_bus_oe(oe));
  sdpi_dimm_model u_sdpi_dimm_model (.i_mclk(mclk), .i_wide_sel(wide),
    .i_strap_en(sen), .i_strap(strap), .i_cs_n(cs_n), .i_s2(s2), .i_s3(s3),
    .i_ma(ma), .i_ba0(ba0), .i_cmd({ras_n[0], cas_n[0], we_n}), .i_dqm(dqm),
    .i_dq(mdq), .o_dq(mdm), .o_act_pins(actp), .o_col_pins(colp));

  // ==========================================================
  // Verdict and hang guard
  // ==========================================================
  task automatic end_sim;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Three boots need well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim;
    end
  end

  // ==========================================================
  // Access tasks
  // ==========================================================
  // Pin image at activate: selects steered by density and bank count
  function automatic logic [15:0] exp_act(input logic [2:0] c,
      input logic [1:0] rk);
    logic [3:0] sel;
    sel = ~(4'h1 << rk);
    if (c[0]) return {sel[3], sel[2], bank[0], row[10:0], sel[1:0]};
    return {c[1] ? bank[1] : row[12], row[11], bank[0], row[10:0], sel[1:0]};
  endfunction
  // Request held until taken, then wait for its completion
  task automatic req(input logic w, input logic [1:0] rk,
      input logic [MASK_W-1:0] b, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge clk) #2;
    vld = 1; wr = w; rank = rk; be = b; wd = d;
    while (rdy !== 1'b1 && n < 200) begin @(posedge clk) #2; n++; end
    @(posedge clk) #2;
    vld = 0;
    while ((w ? rdy : rdv) !== 1'b1 && n < 400) begin @(posedge clk) #2; n++; end
    `CHK(n < 400, 1'b1)
  endtask
  // Reset with a strap word on the bus, then one write/mask/read run
  task automatic boot(input logic [2:0] cfg);
    int n;
    logic [1:0] rk;
    n = 0;
    rk = cfg[0] ? 2'h2 : 2'h1;
    @(posedge clk) #2;
    rst = 1; rin_n = 0; sen = 1; wide = cfg[0];
    strap = 41'h1_5A5A_5A5A_58 | STRAP_W'(cfg);
    repeat (20) @(posedge clk);
    #2 rst = 0;
    repeat (3) @(posedge clk);
    #2 rin_n = 1;
    while (hrst !== 1'b0 && n < 100) begin @(posedge clk) #2; n++; end
    sen = 0;
    `CHK(n >= RESET_OUT_CYC && n < 100, 1'b1)
    `CHK(rso_n, 1'b1)
    `CHK(so, strap)
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) #2 {ovr, drv} = 2'(k);
      #1 `CHK(dcoe, ovr ? drv : cfg[2])
    end
    req(1'b1, rk, 8'hFF, 64'h0123_4567_89AB_CDEF);
    `CHK(actp, exp_act(cfg, rk))
    `CHK(colp, {1'b0, col[9:0]})
    req(1'b1, rk, 8'h0F, 64'hFEDC_BA98_7654_3210);
    req(1'b0, rk, 8'hFF, 64'h0);
    `CHK(rdd, 64'h0123_4567_7654_3210)
    `CHK(so, strap)
  endtask

  initial begin
    boot(3'h0);
    boot(3'h6);
    boot(3'h1);
    end_sim;
  end
endmodule // sdpi_top_tb_top
